/* File: logic/vss_pkg.sv */
// Purpose: Shared constants and types for the soft-start and reference sequencer.
// Assumes: 250 MHz clock, comparator levels arrive already digitised.
// Notes: Reference codes count 6.25 mV steps above the lowest setpoint.
package vss_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned STARTUP_WAIT_TIME_NS = 1360000;
	localparam int unsigned READY_DELAY_TIME_NS = 85000;
	localparam int unsigned STARTUP_WAIT_CYCLES = (STARTUP_WAIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned READY_DELAY_CYCLES = (READY_DELAY_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned SS_PERIOD_CYCLES_DEF = 250;

	// ****************************************************************
	// Code map
	// ****************************************************************
	localparam logic [7:0] VID_LOWEST = 8'h00B2;
	localparam logic [7:0] VID_OFF_A = 8'h00FE;
	localparam logic [7:0] VID_OFF_B = 8'h00FF;
	localparam logic [7:0] VID_TOP_VALID = 8'h0002;
	localparam logic [7:0] REF_RESET = 8'h0000;

	typedef enum logic [4:0] {
		ST_SHUTDOWN = 5'h01,
		ST_WAIT = 5'h02,
		ST_RAMP = 5'h04,
		ST_READY_DLY = 5'h08,
		ST_REGULATE = 5'h10
	} vss_state_e;

	typedef struct packed {
		logic supply_ok;
		logic power_enable_in;
		logic termination_rail_enable_in;
	} vss_qual_s;

	typedef struct packed {
		logic valid;
		logic off;
		logic [7:0] target;
	} vss_decode_s;

endpackage

/* File: logic/vss_vid_decode.sv */
// Purpose: Turns an identification code into a reference step count.
// Assumes: Code is stable at the clock.
// Notes: Output is registered, one cycle of latency.
module vss_vid_decode
	import vss_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Code in and decoded out
	input wire logic [7:0] voltage_id_code,
	output vss_pkg::vss_decode_s decode_out
);
	vss_decode_s dec_d;
	vss_decode_s dec_q;

	always_comb
	begin
		dec_d.off = (voltage_id_code == VID_OFF_A) || (voltage_id_code == VID_OFF_B);
		dec_d.valid = (voltage_id_code >= VID_TOP_VALID) && (voltage_id_code <= VID_LOWEST);
		// Higher codes mean lower voltage, so the step count is distance from the bottom.
		dec_d.target = dec_d.valid ? VID_LOWEST - voltage_id_code : REF_RESET;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			dec_q <= '0;
		else
			dec_q <= dec_d;
	end

	assign decode_out = dec_q;
endmodule

/* File: logic/vss_sequencer.sv */
// Purpose: Start-up sequencer and digital reference ramp of a multiphase regulator.
// Assumes: Supply and enable levels come from hysteretic comparators outside.
// Notes: The ramp pace is a parameter standing for the resistor-set oscillator.

// Functional notes
// - Decode 8-bit code to setpoint, 6.25 mV per code, lowest 0.5 V at 0xB2.
// - OFF codes at enable shut down until supply or an enable is cycled.
// - Phase outputs are high impedance while in shutdown.
// - Leave shutdown only on supply rising level; falling level disables again.
// - Stay in shutdown until power enable is above threshold, with hysteresis.
// - Termination rail enable must also be above threshold to start.
// - All qualified and valid code starts soft-start toward the setpoint.
// - Wait a fixed 1.36 ms before the ramp begins.
// - Ramp raises reference by one 6.25 mV step until equal to setpoint.
// - Each ramp step lasts one soft-start oscillator period.
// - Ready asserts a fixed 85 us after reference reaches setpoint.
// - In regulation, follow code changes step by step without jumps.
// - Ready is low whenever disabled by supply, enables or OFF code.
module vss_sequencer
	import vss_pkg::*;
#(
	parameter int unsigned WAIT_CYCLES = STARTUP_WAIT_CYCLES,
	parameter int unsigned READY_CYCLES = READY_DELAY_CYCLES,
	parameter int unsigned SS_PERIOD_CYCLES = SS_PERIOD_CYCLES_DEF
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Qualified levels and processor code
	input vss_pkg::vss_qual_s qual_in,
	input wire logic [7:0] voltage_id_code,
	// Phase stage control
	output logic phase_drive_en,
	// Reference and status
	output logic [7:0] reference_code,
	output logic ramp_active,
	output logic regulator_ready_out,
	output logic regulator_ready_oe
);
	import vss_pkg::*;

	// ****************************************************************
	// Decode and qualification
	// ****************************************************************
	vss_decode_s dec;
	logic enabled;
	logic enabled_prev_q;
	logic off_latch_q;
	logic off_latch_d;

	vss_vid_decode u_decode (
		.clock(clock),
		.reset(reset),
		.voltage_id_code(voltage_id_code),
		.decode_out(dec)
	);

	// The comparators own the hysteresis; here the levels are simply all required.
	assign enabled = qual_in.supply_ok && qual_in.power_enable_in
		&& qual_in.termination_rail_enable_in;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	localparam int unsigned CW = 22;
	vss_state_e state_q;
	vss_state_e state_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [CW-1:0] ss_q;
	logic [CW-1:0] ss_d;
	logic [7:0] ref_q;
	logic [7:0] ref_d;
	logic tick;

	assign tick = (ss_q == CW'(SS_PERIOD_CYCLES - 1));

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		ref_d = ref_q;
		ss_d = (state_q == ST_RAMP || state_q == ST_REGULATE) && !tick ? ss_q + 1'b1 : '0;
		off_latch_d = off_latch_q;
		// Loss of enable clears a latched OFF shutdown.
		if (!enabled)
			off_latch_d = 1'b0;
		case (state_q)
			ST_SHUTDOWN:
			begin
				ref_d = REF_RESET;
				cnt_d = '0;
				if (enabled && !off_latch_q && !enabled_prev_q && dec.off)
					off_latch_d = 1'b1;
				else if (enabled && !off_latch_q && dec.valid)
					state_d = ST_WAIT;
			end
			ST_WAIT:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CW'(WAIT_CYCLES - 1))
				begin
					cnt_d = '0;
					state_d = ST_RAMP;
				end
			end
			ST_RAMP:
			begin
				// A code raised in mid-ramp can leave the reference above the target.
				// Stopping there avoids counting on through the wrap; regulation slews it down.
				if (ref_q >= dec.target)
					state_d = ST_READY_DLY;
				else if (tick)
					ref_d = ref_q + 1'b1;
			end
			ST_READY_DLY:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CW'(READY_CYCLES - 1))
					state_d = ST_REGULATE;
			end
			ST_REGULATE:
			begin
				// Slew toward a new code one step per period so the output never jumps.
				if (tick && dec.valid && ref_q < dec.target)
					ref_d = ref_q + 1'b1;
				else if (tick && dec.valid && ref_q > dec.target)
					ref_d = ref_q - 1'b1;
			end
			default:
				state_d = ST_SHUTDOWN;
		endcase
		if (!enabled)
			state_d = ST_SHUTDOWN;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state_q <= ST_SHUTDOWN;
			cnt_q <= '0;
			ss_q <= '0;
			ref_q <= REF_RESET;
			off_latch_q <= 1'b0;
			enabled_prev_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			ss_q <= ss_d;
			ref_q <= ref_d;
			off_latch_q <= off_latch_d;
			enabled_prev_q <= enabled;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	logic rdy_q;
	logic drv_q;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			rdy_q <= 1'b0;
			drv_q <= 1'b0;
		end
		else
		begin
			rdy_q <= (state_d == ST_REGULATE);
			drv_q <= (state_d != ST_SHUTDOWN);
		end
	end

	assign phase_drive_en = drv_q;
	assign reference_code = ref_q;
	assign ramp_active = (state_q == ST_RAMP);
	// Open drain: pulled low while not ready, released otherwise.
	assign regulator_ready_out = 1'b0;
	assign regulator_ready_oe = !rdy_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_ramp_done;
		state_q == ST_RAMP && ref_q == dec.target;
	endsequence

	AST_SHUTDOWN_HIZ: assert property (@(posedge clock) disable iff (reset)
		state_q == ST_SHUTDOWN |-> !phase_drive_en)
		else $error("phase outputs driven in shutdown");
	AST_LOSS_TO_SHUTDOWN: assert property (@(posedge clock) disable iff (reset)
		!enabled |=> state_q == ST_SHUTDOWN)
		else $error("no return to shutdown on loss of enable");
	AST_READY_LOW_DISABLED: assert property (@(posedge clock) disable iff (reset)
		!enabled |=> regulator_ready_oe)
		else $error("ready released while disabled");
	AST_WAIT_LEN: assert property (@(posedge clock) disable iff (reset)
		state_q == ST_WAIT && enabled && cnt_q != CW'(WAIT_CYCLES - 1) |=> state_q == ST_WAIT)
		else $error("wait state left early");
	AST_WAIT_END: assert property (@(posedge clock) disable iff (reset)
		state_q == ST_WAIT && enabled && cnt_q == CW'(WAIT_CYCLES - 1) |=> state_q == ST_RAMP)
		else $error("ramp did not follow the wait");
	AST_STEP_ONE: assert property (@(posedge clock) disable iff (reset)
		state_q == ST_RAMP && $changed(ref_q) |-> ref_q == $past(ref_q) + 8'h0001)
		else $error("ramp step not one code");
	AST_STEP_ON_TICK: assert property (@(posedge clock) disable iff (reset)
		state_q == ST_RAMP && $past(state_q) == ST_RAMP && $changed(ref_q) |-> $past(tick))
		else $error("ramp step without oscillator tick");
	AST_RAMP_TO_DELAY: assert property (@(posedge clock) disable iff (reset)
		s_ramp_done ##0 enabled |=> state_q == ST_READY_DLY)
		else $error("ramp end did not start ready delay");
	AST_OFF_LATCH: assert property (@(posedge clock) disable iff (reset)
		off_latch_q && enabled |=> state_q == ST_SHUTDOWN)
		else $error("started while OFF code latched");
	AST_SLEW_LIMIT: assert property (@(posedge clock) disable iff (reset)
		state_q == ST_REGULATE && $past(state_q) == ST_REGULATE
		|-> ref_q - $past(ref_q) inside {8'h0000, 8'h0001, 8'h00FF})
		else $error("reference jumped in regulation");
endmodule

/* File: dv/vss_proc_model.sv */
// Purpose: Processor and rail model driving the code and the enable levels.
// Assumes: Bench commands change just after a rising clock edge.
// Notes: Power enable is held back until the phase drivers finish their power-on.
module vss_proc_model
	import vss_pkg::*;
#(
	parameter int unsigned DRV_POR_CYCLES = 4
)
(
	// Clock
	input wire logic clock,
	// Bench commands
	input vss_pkg::vss_qual_s qual_cmd,
	input wire logic [7:0] code_cmd,
	// Lines into the sequencer
	output vss_pkg::vss_qual_s qual_out,
	output logic [7:0] code_out
);
	timeunit 1ns;
	timeprecision 100ps;

	int drv_cnt = 0;
	vss_qual_s qual_s;
	logic [7:0] code_s;

	initial
	begin
		qual_out = '0;
		code_out = 8'h00FF;
	end

	always @(posedge clock)
	begin
		// Commands are taken at the edge, where they are settled, so the bench cannot race us.
		qual_s = qual_cmd;
		code_s = code_cmd;
		#1;
		drv_cnt = qual_s.supply_ok ? drv_cnt + 1 : 0;
		qual_out.supply_ok = qual_s.supply_ok;
		qual_out.termination_rail_enable_in = qual_s.termination_rail_enable_in;
		// Enabling before the drivers are alive would let them float the phases.
		qual_out.power_enable_in = qual_s.power_enable_in && drv_cnt > DRV_POR_CYCLES;
		code_out = code_s;
	end
endmodule

/* File: dv/test_vid_softstart_sequencer.sv */
// Purpose: Self-checking bench for the start-up sequencer.
// Assumes: Short wait, ready and step counts set through parameters.
// Notes: Expected setpoints and start times come from an integer model.
module test_vid_softstart_sequencer;
	timeunit 1ns;
	timeprecision 100ps;
	import vss_pkg::*;

	// ****************************************************************
	// Signals
	// ****************************************************************
	localparam int SS = 3;
	logic clock = 1'b0;
	logic reset = 1'b1;
	vss_qual_s qual_cmd = '0;
	logic [7:0] code_cmd = 8'h00FF;
	vss_qual_s qual_in;
	logic [7:0] voltage_id_code;
	logic phase_drive_en;
	logic ramp_active;
	logic regulator_ready_out;
	logic regulator_ready_oe;
	logic [7:0] reference_code;
	logic [7:0] ref_prev = 8'h0000;
	int errors = 0;
	int n_checks = 0;
	logic [7:0] bad [5] = '{8'h00FE, 8'h00FF, 8'h0000, 8'h0001, 8'h00B3};

	always #2 clock = ~clock;

	vss_proc_model vss_proc_model_inst (.clock(clock), .qual_cmd(qual_cmd), .code_cmd(code_cmd),
		.qual_out(qual_in), .code_out(voltage_id_code));
	vss_sequencer #(.WAIT_CYCLES(10), .READY_CYCLES(5), .SS_PERIOD_CYCLES(SS)) vss_sequencer_inst (
		.clock(clock), .reset(reset), .qual_in(qual_in), .voltage_id_code(voltage_id_code),
		.phase_drive_en(phase_drive_en), .reference_code(reference_code),
		.ramp_active(ramp_active), .regulator_ready_out(regulator_ready_out),
		.regulator_ready_oe(regulator_ready_oe));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
			errors++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic stop_test;
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Raises all rails with the given code and waits for ready or a bound.
	task automatic start(input logic [7:0] code, input bit ok);
		int t;
		int n;
		int r;
		t = 178 - int'(code);
		code_cmd = code;
		tick(3);
		qual_cmd = '1;
		n = 0;
		while (!(&qual_in) && n < 50)
		begin
			tick(1);
			n++;
		end
		n = 0;
		r = 0;
		while (regulator_ready_oe !== 1'b0 && n < SS * 180 + 60)
		begin
			tick(1);
			n++;
			r += int'(ramp_active === 1'b1);
		end
		if (ok)
		begin
			check("start_time", 8'h0001, 8'(n >= SS * t + 10 && n <= SS * t + 30));
			check("reference_code", 8'(t), reference_code);
			check("phase_drive_en", 8'h0001, 8'(phase_drive_en));
			check("ramp_cycles", 8'h0001, 8'(r == SS * t + 1));
			check("regulator_ready_out", 8'h0000, 8'(regulator_ready_out));
		end
		else
		begin
			check("phase_drive_en", 8'h0000, 8'(phase_drive_en));
			check("ramp_cycles", 8'h0000, 8'(r));
			check("regulator_ready_oe", 8'h0001, 8'(regulator_ready_oe));
		end
	endtask

	task automatic stop(input int bitn);
		qual_cmd[bitn] = 1'b0;
		tick(5);
		check("drive_en_after_drop", 8'h0000, 8'(phase_drive_en));
		check("ready_oe_after_drop", 8'h0001, 8'(regulator_ready_oe));
		qual_cmd = '0;
		tick(3);
	endtask

	// ****************************************************************
	// Monitor and sequence
	// ****************************************************************
	// The reference may only move one step at a time while ramping or regulating.
	always @(negedge clock)
	begin
		if (!reset && reference_code !== ref_prev && (ramp_active === 1'b1 || regulator_ready_oe === 1'b0))
			check("ref_step", 8'h0001, 8'(reference_code - ref_prev == 8'h01
				|| ref_prev - reference_code == 8'h01));
		ref_prev = reference_code;
	end

	initial
	begin
		repeat (40000) @(posedge clock);
		errors++;
		stop_test;
	end

	initial
	begin
		int c;
		int c2;
		void'($urandom(89));
		tick(5);
		reset = 1'b0;
		foreach (bad[i])
		begin
			start(bad[i], 1'b0);
			if (i < 2)
			begin
				code_cmd = 8'h0040;
				tick(30);
				check("off_latched", 8'h0000, 8'(phase_drive_en));
			end
			qual_cmd = '0;
			tick(4);
		end
		for (int i = 0; i < 6; i++)
		begin
			c = i == 0 ? 178 : i == 1 ? 2 : 2 + $urandom % 177;
			start(8'(c), 1'b1);
			if (i >= 2)
			begin
				c2 = 2 + $urandom % 177;
				code_cmd = 8'(c2);
				tick(SS * (c > c2 ? c - c2 : c2 - c) + 20);
				check("reference_follow", 8'(178 - c2), reference_code);
			end
			stop(i % 3);
		end
		stop_test;
	end
endmodule
